// ==== bfs_device.sv ====
`timescale 1ns/1ps
`include "bfs_map.svh"
module bfs_device #(
	parameter int FILT_CYC = `BFS_FILT_CYC,
	parameter int SC_CYC = `BFS_SC_FILT_CYC,
	parameter int RL_CYC = `BFS_RL_SINK_CYC,
	parameter int CP_CYC = `BFS_CHARGE_PUMP_LOW_FLAG_CYC,
	parameter int WD_CYC = `BFS_WD_CYC
) (
	input wire logic mclk,
	input wire logic rst_b,
	bfs_if.device bus,
	input wire logic ov_hi_raw,
	input wire logic ov_lo_raw,
	input wire logic uv_raw,
	input wire logic charge_pump_low_flag_raw,
	input wire logic tw_raw,
	input wire logic tsd_raw,
	input wire logic tsd_release_raw,
	input wire logic ext_off_raw,
	input wire logic stuck_raw,
	input wire logic [1:0] sc_raw
);
	// flags: 0 ov,1 uv,2 charge_pump_low_flag,3 tw,4 tsd,5 wdto,6 ext,7 sc0,8 sc1,9 global
	localparam int NRAW = 10;
	logic [NRAW-1:0] s1_ff;
	logic [NRAW-1:0] s2_ff;
	logic [1:0] sc1_ff;
	logic [1:0] sc2_ff;
	logic [NRAW-1:0] raw;
	logic ovd;
	logic [1:0] schit;
	logic ov_hit, uv_hit, cp_hit, tw_hit, tsd_hit, ext_hit;
	logic [9:0] flag_ff;
	logic glob_ff;
	logic [31:0] wd_ff;
	logic wd_to;
	logic cp_en_ff;
	logic [1:0] gh_ff, gl_ff;
	bfs_pkg::bfs_rl_st_t rl_st_ff;
	logic [31:0] rl_cnt_ff;
	logic rl_fail, rl_any, sink_all, ext_now;
	logic [1:0] hb_sink;
	assign raw = {stuck_raw, tsd_release_raw, ext_off_raw, tsd_raw, tw_raw, charge_pump_low_flag_raw,
		uv_raw, ov_lo_raw, ov_hi_raw, 1'b0};
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s1_ff <= '0;
			s2_ff <= '0;
			sc1_ff <= 2'h0;
			sc2_ff <= 2'h0;
		end else begin
			s1_ff <= raw;
			s2_ff <= s1_ff;
			sc1_ff <= sc_raw;
			sc2_ff <= sc1_ff;
		end
	end
	// threshold select chooses which comparator feeds the filter
	assign ovd = bus.ovsel ? s2_ff[2] : s2_ff[1];
	bfs_filter #(.CYC(FILT_CYC)) u_ov (.mclk(mclk), .rst_b(rst_b), .cond(ovd), .hit(ov_hit));
	bfs_filter #(.CYC(FILT_CYC)) u_uv (.mclk(mclk), .rst_b(rst_b), .cond(s2_ff[3]),
		.hit(uv_hit));
	bfs_filter #(.CYC(CP_CYC)) u_cp (.mclk(mclk), .rst_b(rst_b),
		.cond(s2_ff[4] && cp_en_ff), .hit(cp_hit));
	bfs_filter #(.CYC(FILT_CYC)) u_tw (.mclk(mclk), .rst_b(rst_b), .cond(s2_ff[5]),
		.hit(tw_hit));
	bfs_filter #(.CYC(FILT_CYC)) u_tsd (.mclk(mclk), .rst_b(rst_b), .cond(s2_ff[6]),
		.hit(tsd_hit));
	bfs_filter #(.CYC(FILT_CYC)) u_ext (.mclk(mclk), .rst_b(rst_b),
		.cond(s2_ff[7] && bus.ext_ts), .hit(ext_hit));
	bfs_filter #(.CYC(SC_CYC)) u_sc0 (.mclk(mclk), .rst_b(rst_b),
		.cond(sc2_ff[0] && bus.en), .hit(schit[0]));
	bfs_filter #(.CYC(SC_CYC)) u_sc1 (.mclk(mclk), .rst_b(rst_b),
		.cond(sc2_ff[1] && bus.en), .hit(schit[1]));
	assign wd_to = (wd_ff >= WD_CYC - 1);
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wd_ff <= 32'h0;
		end else if (bus.wd_restart || !bus.en || flag_ff[5]) begin
			wd_ff <= 32'h0;
		end else begin
			wd_ff <= wd_ff + 32'h1;
		end
	end
	// set wins over clear; tsd clears only once cooled below release
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			flag_ff <= 10'h0;
		end else begin
			flag_ff[0] <= ov_hit | (flag_ff[0] & ~bus.clear_pulse);
			flag_ff[1] <= uv_hit | (flag_ff[1] & ~bus.clear_pulse);
			flag_ff[2] <= cp_hit | (flag_ff[2] & ~bus.clear_pulse);
			flag_ff[3] <= tw_hit | (flag_ff[3] & ~bus.clear_pulse);
			flag_ff[4] <= tsd_hit | (flag_ff[4] & ~(bus.clear_pulse & s2_ff[8]));
			flag_ff[5] <= wd_to | (flag_ff[5] & ~bus.clear_pulse);
			flag_ff[6] <= ext_hit | (flag_ff[6] & ~bus.clear_pulse);
			flag_ff[7] <= schit[0] | (flag_ff[7] & ~bus.clear_pulse);
			flag_ff[8] <= schit[1] | (flag_ff[8] & ~bus.clear_pulse);
			flag_ff[9] <= s2_ff[9];
		end
	end
	// global error is registered so the flag word leaves the block from flops
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			glob_ff <= 1'b0;
		end else begin
			glob_ff <= flag_ff[9] | (|flag_ff[8:4]) | (|flag_ff[2:0]);
		end
	end
	// the pump stays off after ov/uv only while recovery is disabled
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cp_en_ff <= 1'b0;
		end else begin
			cp_en_ff <= bus.en && !ovd && !s2_ff[3] && !flag_ff[4] && !tsd_hit
				&& !(bus.recdis && (flag_ff[0] || flag_ff[1]));
		end
	end
	assign rl_fail = flag_ff[4] | flag_ff[2] | (bus.ext_ts & flag_ff[6]);
	assign rl_any = rl_fail | !bus.en | flag_ff[9];
	// active-off mode acts at once and is not latched
	assign ext_now = !bus.ext_ts && s2_ff[7];
	assign sink_all = flag_ff[0] | flag_ff[1] | flag_ff[5] | ext_now;
	assign hb_sink = flag_ff[8:7];
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rl_st_ff <= bfs_pkg::BFS_RL_RESIST;
			rl_cnt_ff <= 32'h0;
		end else begin
			case (rl_st_ff)
				bfs_pkg::BFS_RL_IDLE: begin
					rl_cnt_ff <= 32'h0;
					if (rl_fail) begin
						rl_st_ff <= bfs_pkg::BFS_RL_SINKING;
					end else if (rl_any) begin
						rl_st_ff <= bfs_pkg::BFS_RL_RESIST;
					end
				end
				bfs_pkg::BFS_RL_SINKING: begin
					rl_cnt_ff <= rl_cnt_ff + 32'h1;
					if (!rl_any) begin
						rl_st_ff <= bfs_pkg::BFS_RL_IDLE;
					end else if (rl_cnt_ff >= RL_CYC - 1) begin
						rl_st_ff <= bfs_pkg::BFS_RL_RESIST;
					end
				end
				bfs_pkg::BFS_RL_RESIST: begin
					rl_cnt_ff <= 32'h0;
					if (!rl_any) begin
						rl_st_ff <= bfs_pkg::BFS_RL_IDLE;
					end
				end
				default: rl_st_ff <= bfs_pkg::BFS_RL_RESIST;
			endcase
		end
	end
	// gh/gl coding: 1 = source; rl shows gh low with gl held by resistive state
	// resistive low lags the state by one cycle, the sink phase covers it
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			gh_ff <= 2'h0;
			gl_ff <= 2'h3;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (rl_st_ff == bfs_pkg::BFS_RL_RESIST) begin
					gh_ff[i] <= 1'b0;
					gl_ff[i] <= 1'b1;
				end else if (rl_st_ff != bfs_pkg::BFS_RL_IDLE || rl_any || sink_all
					|| hb_sink[i]) begin
					gh_ff[i] <= 1'b0;
					gl_ff[i] <= 1'b0;
				end else begin
					gh_ff[i] <= bus.hb_cmd[i];
					gl_ff[i] <= !bus.hb_cmd[i] && bus.pwm;
				end
			end
		end
	end
	assign bus.flags = {glob_ff, flag_ff[8:0]};
	assign bus.gh = gh_ff;
	assign bus.gl = gl_ff;
	assign bus.cp_enable = cp_en_ff;
endmodule : bfs_device

// ==== bfs_map.svh ====
`ifndef BFS_MAP_SVH
`define BFS_MAP_SVH
`define BFS_CLK_MHZ 50
`define BFS_FILT_US 64
`define BFS_SC_FILT_US 6
`define BFS_RL_SINK_MIN_US 32
`define BFS_RL_SINK_MAX_US 64
`define BFS_FILT_CYC (`BFS_FILT_US * `BFS_CLK_MHZ)
`define BFS_SC_FILT_CYC (`BFS_SC_FILT_US * `BFS_CLK_MHZ)
`define BFS_RL_SINK_CYC (((`BFS_RL_SINK_MIN_US + `BFS_RL_SINK_MAX_US) / 2) * `BFS_CLK_MHZ)
`define BFS_CHARGE_PUMP_LOW_FLAG_CYC 3200
`define BFS_ADDR_STATUS 8'h00
`define BFS_ADDR_CTRL 8'h04
`define BFS_ADDR_CMD 8'h08
`define BFS_ADDR_GATES 8'h0c
`define BFS_CTRL_OVSEL 0
`define BFS_CTRL_RECDIS 1
`define BFS_CTRL_EXTTS 2
`define BFS_CTRL_EN 3
`define BFS_GATES_DIR 0
`define BFS_GATES_PWM 1
`define BFS_CMD_CLEAR 0
`define BFS_CMD_WDRST 1
`define BFS_WD_CYC 3000000
`endif

// ==== bfs_pkg.sv ====
package bfs_pkg;
	typedef enum logic [1:0] {
		BFS_G_SINK,
		BFS_G_SOURCE,
		BFS_G_RL,
		BFS_G_TRI
	} bfs_gate_t;
	typedef enum logic [1:0] {
		BFS_RL_IDLE,
		BFS_RL_SINKING,
		BFS_RL_RESIST
	} bfs_rl_st_t;
endpackage : bfs_pkg

// ==== bfs_if.sv ====
`timescale 1ns/1ps
interface bfs_if;
	logic en;
	logic dir;
	logic pwm;
	logic [1:0] hb_cmd;
	logic ovsel;
	logic recdis;
	logic ext_ts;
	logic clear_pulse;
	logic wd_restart;
	logic [9:0] flags;
	logic [1:0] gh;
	logic [1:0] gl;
	logic cp_enable;
	modport device (
		input en, dir, pwm, hb_cmd, ovsel, recdis, ext_ts, clear_pulse, wd_restart,
		output flags, gh, gl, cp_enable
	);
	modport host (
		output en, dir, pwm, hb_cmd, ovsel, recdis, ext_ts, clear_pulse, wd_restart,
		input flags, gh, gl, cp_enable
	);
endinterface : bfs_if

// ==== bfs_filter.sv ====
`timescale 1ns/1ps
module bfs_filter #(
	parameter int CYC = 3200
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic cond,
	output logic hit
);
	logic [31:0] cnt_ff;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= 32'h0;
		end else if (!cond) begin
			cnt_ff <= 32'h0;
		end else if (cnt_ff < CYC) begin
			cnt_ff <= cnt_ff + 32'h1;
		end
	end
	// hit once the condition has stayed on for the whole filter time
	assign hit = cond && (cnt_ff >= CYC - 1);
endmodule : bfs_filter

// ==== bfs_host.sv ====
`timescale 1ns/1ps
`include "bfs_map.svh"
module bfs_host (
	input wire logic mclk,
	input wire logic rst_b,
	bfs_if.host bus,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata
);
	logic [3:0] ctrl_ff;
	logic [2:0] pins_ff;
	logic clr_ff, wdr_ff;
	logic [31:0] rdata_ff;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_ff <= 4'h0;
			pins_ff <= 3'h0;
		end else if (wr && addr == `BFS_ADDR_CTRL) begin
			ctrl_ff <= wdata[3:0];
		end else if (wr && addr == `BFS_ADDR_GATES) begin
			pins_ff <= wdata[2:0];
		end
	end
	// clearing is a one-cycle pulse; it is the only way back after a latched fault, stuck and active-off recover alone
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			clr_ff <= 1'b0;
			wdr_ff <= 1'b0;
		end else begin
			clr_ff <= wr && addr == `BFS_ADDR_CMD && wdata[`BFS_CMD_CLEAR];
			wdr_ff <= wr && addr == `BFS_ADDR_CMD && wdata[`BFS_CMD_WDRST];
		end
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= 32'h0;
		end else if (rd) begin
			case (addr)
				`BFS_ADDR_STATUS: rdata_ff <= {17'h0, bus.cp_enable, bus.gl, bus.gh, bus.flags};
				`BFS_ADDR_CTRL: rdata_ff <= {28'h0, ctrl_ff};
				`BFS_ADDR_GATES: rdata_ff <= {29'h0, pins_ff};
				default: rdata_ff <= 32'h0;
			endcase
		end else begin
			rdata_ff <= 32'h0;
		end
	end
	assign rdata = rdata_ff;
	assign bus.en = ctrl_ff[`BFS_CTRL_EN];
	assign bus.ovsel = ctrl_ff[`BFS_CTRL_OVSEL];
	assign bus.recdis = ctrl_ff[`BFS_CTRL_RECDIS];
	assign bus.ext_ts = ctrl_ff[`BFS_CTRL_EXTTS];
	assign bus.dir = pins_ff[`BFS_GATES_DIR];
	assign bus.pwm = pins_ff[`BFS_GATES_PWM];
	// dir low drives the second halfbridge high, dir high the first
	assign bus.hb_cmd = {~pins_ff[`BFS_GATES_DIR] & pins_ff[`BFS_GATES_PWM],
		pins_ff[`BFS_GATES_DIR] & pins_ff[`BFS_GATES_PWM]};
	assign bus.clear_pulse = clr_ff;
	assign bus.wd_restart = wdr_ff;
endmodule : bfs_host

// ==== bfs_checker.sv ====
`timescale 1ns/1ps
module bfs_checker (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic en,
	input wire logic dir,
	input wire logic pwm,
	input wire logic [1:0] hb_cmd,
	input wire logic clear_pulse,
	input wire logic [9:0] flags,
	input wire logic [1:0] gh,
	input wire logic [1:0] gl,
	input wire logic cp_enable
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	// three cycles of slack, the gate outputs are registered
	a_standby_off: assert property ((!en) [*3] |-> !cp_enable && gh == 2'b00)
		else $error("standby left gates or pump on");
	a_ov_sinks: assert property (flags[0] [*3] |-> {gh, gl} == 4'h0)
		else $error("overvoltage did not sink gates");
	a_uv_sinks: assert property (flags[1] [*3] |-> {gh, gl} == 4'h0)
		else $error("undervoltage did not sink gates");
	a_tsd_off: assert property (flags[4] [*3] |-> !cp_enable && gh == 2'b00)
		else $error("thermal shutdown left gates or pump on");
	a_charge_pump_low_flag_off: assert property (flags[2] [*3] |-> gh == 2'b00)
		else $error("pump low left high side on");
	a_sc_own_bridge: assert property (flags[7] [*3] |-> gh[0] == 1'b0 && gl[0] == 1'b0)
		else $error("short circuit did not sink its bridge");
	a_tw_no_effect: assert property ($rose(flags[3]) && $stable({dir, pwm, hb_cmd, en})
		&& flags[8:4] == 5'h0 && flags[2:0] == 3'h0 |-> $stable({gh, gl}))
		else $error("temperature warning moved a gate");
	a_ov_held: assert property ($fell(flags[0]) |-> $past(clear_pulse))
		else $error("overvoltage flag dropped without clear");
	a_tsd_held: assert property (flags[4] && !clear_pulse |=> flags[4])
		else $error("thermal shutdown flag dropped without clear");
	a_charge_pump_low_flag_held: assert property ($fell(flags[2]) |-> $past(clear_pulse, 1))
		else $error("pump low flag dropped without clear");
endmodule : bfs_checker

// ==== bfs_test.sv ====
`timescale 1ns/1ps
module bfs_test;
	logic mclk;
	logic rst_b;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic [10:0] raw;
	int bad_count;
	int compares;
	int cyc;
	bfs_if bfs_if_i ();
	bfs_device #(.FILT_CYC(8), .SC_CYC(4), .RL_CYC(6), .CP_CYC(8), .WD_CYC(300)) bfs_device_i (
		.mclk(mclk), .rst_b(rst_b), .bus(bfs_if_i.device), .ov_hi_raw(raw[0]),
		.ov_lo_raw(raw[1]), .uv_raw(raw[2]), .charge_pump_low_flag_raw(raw[3]), .tw_raw(raw[4]),
		.tsd_raw(raw[5]), .tsd_release_raw(raw[6]), .ext_off_raw(raw[7]),
		.stuck_raw(raw[8]), .sc_raw(raw[10:9]));
	bfs_host bfs_host_i (.mclk(mclk), .rst_b(rst_b), .bus(bfs_if_i.host), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	bfs_checker bfs_checker_i (.mclk(mclk), .rst_b(rst_b), .en(bfs_if_i.en),
		.dir(bfs_if_i.dir), .pwm(bfs_if_i.pwm), .hb_cmd(bfs_if_i.hb_cmd),
		.clear_pulse(bfs_if_i.clear_pulse), .flags(bfs_if_i.flags), .gh(bfs_if_i.gh),
		.gl(bfs_if_i.gl), .cp_enable(bfs_if_i.cp_enable));
	task wrap_up;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task wt(input int n);
		repeat (n) @(posedge mclk);
	endtask : wt
	task put_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : put_reg
	// status word: pump, low gates, high gates, flags
	task look(input logic [7:0] a, input logic [14:0] m, input logic [14:0] e);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 check(rdata & {17'h0, m}, {17'h0, e});
	endtask : look
	task clr;
		put_reg(8'h08, 32'h3);
		wt(4);
	endtask : clr
	// raise one condition, drop it, clear, back to plain drive
	task flt(input int b, input logic [14:0] e1, m1, e2, m2);
		raw[b] <= 1'b1;
		wt(24);
		look(8'h00, m1, e1);
		raw[b] <= 1'b0;
		wt(24);
		look(8'h00, m2, e2);
		clr;
		look(8'h00, 15'h7fff, 15'h5800);
		$display("test done: condition %0d", b);
	endtask : flt
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 4000) begin
			bad_count++;
			wrap_up;
		end
	end
	initial begin
		rst_b = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		raw = 11'h040;
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		look(8'h00, 15'h7fff, 15'h3000);
		look(8'h10, 15'h7fff, 15'h0000);
		put_reg(8'h0c, 32'h2);
		put_reg(8'h04, 32'h8);
		wt(24);
		look(8'h00, 15'h7fff, 15'h5800);
		$display("test done: reset and drive");
		// short pulses never fill the long filter, the short-circuit one fills fast
		repeat (3) begin
			raw[2] <= 1'b1;
			wt(6);
			raw[2] <= 1'b0;
			wt(1);
		end
		raw[9] <= 1'b1;
		wt(8);
		raw[9] <= 1'b0;
		wt(4);
		look(8'h00, 15'h0082, 15'h0080);
		clr;
		$display("test done: filters");
		flt(2, 15'h0202, 15'h7fff, 15'h4202, 15'h7fff);
		flt(0, 15'h0201, 15'h7fff, 15'h4201, 15'h7fff);
		put_reg(8'h04, 32'h9);
		raw[0] <= 1'b1;
		wt(24);
		look(8'h00, 15'h0001, 15'h0000);
		raw[0] <= 1'b0;
		flt(1, 15'h0201, 15'h7fff, 15'h4201, 15'h7fff);
		flt(5, 15'h3210, 15'h7fff, 15'h3210, 15'h7fff);
		flt(3, 15'h3204, 15'h3fff, 15'h3204, 15'h3fff);
		flt(4, 15'h5808, 15'h7dff, 15'h5800, 15'h7df7);
		flt(9, 15'h4a80, 15'h7fff, 15'h4a80, 15'h7fff);
		raw[6] <= 1'b0;
		raw[5] <= 1'b1;
		wt(24);
		raw[5] <= 1'b0;
		wt(4);
		clr;
		look(8'h00, 15'h0010, 15'h0010);
		raw[6] <= 1'b1;
		wt(4);
		clr;
		look(8'h00, 15'h7fff, 15'h5800);
		raw[7] <= 1'b1;
		wt(6);
		look(8'h00, 15'h3c00, 15'h0000);
		raw[7] <= 1'b0;
		wt(6);
		look(8'h00, 15'h3c00, 15'h1800);
		put_reg(8'h04, 32'hd);
		raw[7] <= 1'b1;
		wt(24);
		look(8'h00, 15'h0040, 15'h0040);
		raw[7] <= 1'b0;
		wt(4);
		clr;
		look(8'h00, 15'h7fff, 15'h5800);
		put_reg(8'h04, 32'h0);
		wt(24);
		look(8'h00, 15'h7fff, 15'h3000);
		put_reg(8'h04, 32'h8);
		wt(24);
		look(8'h00, 15'h7fff, 15'h5800);
		$display("test done: external off and standby");
		wt(340);
		look(8'h00, 15'h3fff, 15'h0220);
		clr;
		look(8'h00, 15'h7fff, 15'h5800);
		$display("test done: watchdog");
		wrap_up;
	end
endmodule : bfs_test
